// *** fpk_defs.svh ***
`ifndef FPK_DEFS_SVH
`define FPK_DEFS_SVH

// --------------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------------
`define FPK_CLK_HZ 10000000
`define FPK_IDLE_MIN 15
`define FPK_IDLE_CYC (64'(`FPK_IDLE_MIN) * 64'd60 * 64'(`FPK_CLK_HZ))
`define FPK_DB_MS 10
`define FPK_DB_CYC ((`FPK_DB_MS * (`FPK_CLK_HZ / 1000)))
`define FPK_TMR_W 36

// --------------------------------------------------------------------
// display geometry and contrast
// --------------------------------------------------------------------
`define FPK_LCD_ROWS 4
`define FPK_LCD_COLS 20
`define FPK_CONTRAST_RST 4'h8
`define FPK_CONTRAST_MAX 4'hF
`define FPK_CONTRAST_MIN 4'h0

// --------------------------------------------------------------------
// keypad, menu and leds
// --------------------------------------------------------------------
`define FPK_NAV_KEYS 9
`define FPK_ALNUM_N 10
`define FPK_MENU_DEPTH 8
`define FPK_LED_N 16
`define FPK_LED_OK_IDX 0
`define FPK_LED_TAG_IDX 1

`endif

// *** fpk_pkg.sv ***
package fpk_pkg;

	// menu mode, one-hot
	typedef enum logic [3:0] {
		FPK_NAV = 4'h1,
		FPK_EDIT = 4'h2,
		FPK_RESET = 4'h4,
		FPK_FUNCTION_KEY = 4'h8
	} fpk_mode_t;

	// kind of the item currently selected, from the settings core
	typedef enum logic [2:0] {
		FPK_ITEM_MENU = 3'h0,
		FPK_ITEM_OPTION = 3'h1,
		FPK_ITEM_NUMERIC = 3'h2,
		FPK_ITEM_PASSWORD = 3'h3,
		FPK_ITEM_SCALAR = 3'h4,
		FPK_ITEM_RESETTABLE = 3'h5,
		FPK_ITEM_READONLY = 3'h6
	} fpk_item_t;

	// commands to the settings core
	typedef enum logic [3:0] {
		FPK_CMD_NONE = 4'h0,
		FPK_CMD_COMMIT = 4'h1,
		FPK_CMD_CANCEL = 4'h2,
		FPK_CMD_EXEC_FUNCTION_KEY = 4'h3,
		FPK_CMD_CONFIRM_RESET = 4'h4,
		FPK_CMD_CONFIRM_PWD = 4'h5,
		FPK_CMD_OPT_PREV = 4'h6,
		FPK_CMD_OPT_NEXT = 4'h7,
		FPK_CMD_SIGN_FLIP = 4'h8,
		FPK_CMD_CASE_FLIP = 4'h9,
		FPK_CMD_CHAR = 4'hA,
		FPK_CMD_SHORTCUT = 4'hB,
		FPK_CMD_SPECIAL = 4'hC
	} fpk_cmd_t;

	// named keys of the keypad
	typedef struct packed {
		logic up;
		logic down;
		logic left;
		logic right;
		logic back_out_key;
		logic enter;
		logic edit;
		logic function_key;
		logic special_char_key;
	} fpk_keys_t;

	// description of the current item, from the settings core
	typedef struct packed {
		logic [5:0] item_count;
		logic has_child;
		fpk_item_t kind;
	} fpk_core_in_t;

	// command to the settings core
	typedef struct packed {
		logic valid;
		fpk_cmd_t cmd;
		logic [7:0] arg;
	} fpk_core_cmd_t;

	// menu position shown to core and display
	typedef struct packed {
		fpk_mode_t mode;
		logic [2:0] depth;
		logic [5:0] item;
		logic [1:0] row;
		logic [4:0] col;
	} fpk_pos_t;

endpackage

// *** fpk_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpk_defs.svh"

module fpk_debounce #(
	parameter int N = 19,
	parameter int DB_CYC = 100000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// raw keys from the pins
	input wire logic [N-1:0] raw,
	// clean level and one press pulse per key
	output logic [N-1:0] level,
	output logic [N-1:0] press
);
	localparam int CW = $clog2(DB_CYC + 1);

	generate
		if (N < 1 || DB_CYC < 1) begin : g_chk
			$error("fpk_debounce: bad parameters");
		end
	endgenerate

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] lvl;
		logic [N-1:0] prs;
		logic [N-1:0][CW-1:0] cnt;
	} fpk_db_t;

	fpk_db_t st_r;
	fpk_db_t st_nxt;

	// RQ20 one press per key
	// sync, then accept a new level only once it stood for DB_CYC cycles
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.prs = '0;
		for (int i = 0; i < N; i++) begin
			if (st_r.s2[i] == st_r.lvl[i]) begin
				st_nxt.cnt[i] = '0;
			end else if (st_r.cnt[i] == CW'(DB_CYC - 1)) begin
				st_nxt.cnt[i] = '0;
				st_nxt.lvl[i] = st_r.s2[i];
				st_nxt.prs[i] = st_r.s2[i];
			end else begin
				st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;
	assign press = st_r.prs;

endmodule
`default_nettype wire

// *** fpk_hmi.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpk_defs.svh"

// Notes on behaviour
// RQ1 - fifteen idle minutes switch off the leds and the backlight
// RQ2 - self-check and live-work-tag leds keep working while saving power
// RQ3 - any key press relights backlight and restores every led
// RQ4 - fifteen idle minutes send the menu back to its root
// RQ5 - display cursor addresses four lines of twenty characters
// RQ6 - function plus up raises contrast, function plus down lowers it
// RQ7 - up selects previous item, first wraps to last
// RQ8 - down selects next item, past last wraps to first
// RQ9 - up or down steps option while editing a selectable option
// RQ10 - up or down flips the sign while editing a number
// RQ11 - up or down toggles letter case while editing a password
// RQ12 - left moves one menu level up
// RQ13 - right descends in navigation, moves cursor right while editing
// RQ14 - back-out goes up in navigation, cancels edit without change
// RQ15 - enter descends, commits, runs function code, confirms reset or password
// RQ16 - edit key enters edit mode or reset mode by item kind
// RQ17 - function key alone enters function-code entry mode
// RQ18 - alphanumeric keys give characters, or menu shortcuts in navigation
// RQ19 - special-char key inserts special characters while editing
// RQ20 - each press restarts both idle timers; one press is one event
module fpk_hmi
	import fpk_pkg::*;
#(
	parameter int ALNUM_N = `FPK_ALNUM_N,
	parameter int LED_N = `FPK_LED_N,
	parameter int LED_OK_IDX = `FPK_LED_OK_IDX,
	parameter int LED_TAG_IDX = `FPK_LED_TAG_IDX,
	parameter logic [`FPK_TMR_W-1:0] IDLE_CYC = `FPK_TMR_W'(`FPK_IDLE_CYC),
	parameter int DB_CYC = `FPK_DB_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// keypad pins
	input wire fpk_pkg::fpk_keys_t keys_raw,
	input wire logic [ALNUM_N-1:0] alnum_raw,
	// settings core
	input wire fpk_pkg::fpk_core_in_t core_in,
	input wire logic [LED_N-1:0] led_want,
	output fpk_pkg::fpk_core_cmd_t core_cmd,
	output fpk_pkg::fpk_pos_t pos,
	// display and leds
	output logic backlight,
	output logic [3:0] contrast,
	output logic [LED_N-1:0] led_out
);
	import fpk_pkg::*;

	localparam int NK = `FPK_NAV_KEYS + ALNUM_N;

	generate
		if (ALNUM_N < 1 || ALNUM_N > 256 || LED_N < 2 || LED_OK_IDX >= LED_N ||
				LED_TAG_IDX >= LED_N || IDLE_CYC < 2) begin : g_chk
			$error("fpk_hmi: bad parameters");
		end
	endgenerate

	// --------------------------------------------------------------
	// key conditioning
	// --------------------------------------------------------------
	logic [NK-1:0] k_lvl;
	logic [NK-1:0] k_prs;
	fpk_keys_t kl;
	fpk_keys_t kp;
	logic [ALNUM_N-1:0] ap;
	logic any_press;

	fpk_debounce #(
		.N(NK),
		.DB_CYC(DB_CYC)
	) u_db (
		.clk(clk),
		.rst(rst),
		.raw({keys_raw, alnum_raw}),
		.level(k_lvl),
		.press(k_prs)
	);

	// split the clean vectors
	assign kl = k_lvl[NK-1:ALNUM_N];
	assign kp = k_prs[NK-1:ALNUM_N];
	assign ap = k_prs[ALNUM_N-1:0];
	assign any_press = |k_prs;

	// leds that never blank
	localparam logic [LED_N-1:0] EXEMPT = (LED_N'(1) << LED_OK_IDX) | (LED_N'(1) << LED_TAG_IDX);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		fpk_mode_t mode;
		fpk_item_t ekind;
		logic [2:0] depth;
		logic [5:0] item;
		logic [1:0] row;
		logic [4:0] col;
		logic [3:0] contrast;
		logic fn_combo;
		logic fn_prev;
		logic [`FPK_TMR_W-1:0] save_tmr;
		logic [`FPK_TMR_W-1:0] root_tmr;
		logic saving;
		logic cmd_valid;
		fpk_cmd_t cmd;
		logic [7:0] arg;
		logic [LED_N-1:0] led;
		logic backlight;
	} fpk_st_t;

	fpk_st_t st_r;
	fpk_st_t st_nxt;

	// previous item with wrap from first to last
	function automatic logic [5:0] prev_item(input logic [5:0] it, input logic [5:0] cnt);
		if (it == 6'h00) begin
			return (cnt == 6'h00) ? 6'h00 : cnt - 6'h01;
		end
		return it - 6'h01;
	endfunction

	// next item with wrap from last to first
	function automatic logic [5:0] next_item(input logic [5:0] it, input logic [5:0] cnt);
		if (it + 6'h01 >= cnt) begin
			return 6'h00;
		end
		return it + 6'h01;
	endfunction

	// index of the lowest pressed alphanumeric key
	function automatic logic [7:0] key_code(input logic [ALNUM_N-1:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = ALNUM_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				c = 8'(i);
			end
		end
		return c;
	endfunction

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.cmd_valid = 1'b0;
		st_nxt.cmd = FPK_CMD_NONE;
		st_nxt.fn_prev = kl.function_key;

		// RQ20 restart idle timers
		if (any_press) begin
			st_nxt.save_tmr = '0;
			st_nxt.root_tmr = '0;
		end else begin
			if (st_r.save_tmr != IDLE_CYC) begin
				st_nxt.save_tmr = st_r.save_tmr + `FPK_TMR_W'(1);
			end
			if (st_r.root_tmr != IDLE_CYC) begin
				st_nxt.root_tmr = st_r.root_tmr + `FPK_TMR_W'(1);
			end
		end

		// RQ1 enter power saving
		if (!any_press && st_r.save_tmr == IDLE_CYC - `FPK_TMR_W'(1)) begin
			st_nxt.saving = 1'b1;
		end
		// RQ3 a press wakes the panel
		if (any_press) begin
			st_nxt.saving = 1'b0;
		end

		// function key combos with arrows
		if (kp.function_key) begin
			st_nxt.fn_combo = 1'b0;
		end
		if (kl.function_key && (kp.up || kp.down)) begin
			st_nxt.fn_combo = 1'b1;
			// RQ6 contrast stepping
			if (kp.up && st_r.contrast != `FPK_CONTRAST_MAX) begin
				st_nxt.contrast = st_r.contrast + 4'h1;
			end else if (kp.down && st_r.contrast != `FPK_CONTRAST_MIN) begin
				st_nxt.contrast = st_r.contrast - 4'h1;
			end
		end else if (st_r.fn_prev && !kl.function_key && !st_r.fn_combo) begin
			// RQ17 lone function key, taken on release
			st_nxt.mode = FPK_FUNCTION_KEY;
			st_nxt.col = 5'h00;
		end else begin
			case (st_r.mode)
				FPK_NAV: begin
					if (kp.up) begin
						// RQ7 previous with wrap
						st_nxt.item = prev_item(st_r.item, core_in.item_count);
						st_nxt.row = (st_r.item == 6'h00) ?
							((core_in.item_count > 6'(`FPK_LCD_ROWS)) ?
							2'(`FPK_LCD_ROWS - 1) : 2'(core_in.item_count - 6'h01)) :
							((st_r.row != 2'h0) ? st_r.row - 2'h1 : 2'h0);
					end else if (kp.down) begin
						// RQ8 next with wrap
						st_nxt.item = next_item(st_r.item, core_in.item_count);
						st_nxt.row = (next_item(st_r.item, core_in.item_count) == 6'h00) ?
							2'h0 : ((st_r.row != 2'(`FPK_LCD_ROWS - 1)) ?
							st_r.row + 2'h1 : st_r.row);
					end else if (kp.left || kp.back_out_key) begin
						// RQ12 one level up
						// RQ14 back-out in navigation
						if (st_r.depth != 3'h0) begin
							st_nxt.depth = st_r.depth - 3'h1;
							st_nxt.item = 6'h00;
							st_nxt.row = 2'h0;
						end
					end else if (kp.right || kp.enter) begin
						// RQ13 right descends
						// RQ15 enter descends
						if (core_in.has_child && st_r.depth != 3'(`FPK_MENU_DEPTH - 1)) begin
							st_nxt.depth = st_r.depth + 3'h1;
							st_nxt.item = 6'h00;
							st_nxt.row = 2'h0;
						end
					end else if (kp.edit) begin
						// RQ16 edit or reset mode
						if (core_in.kind == FPK_ITEM_RESETTABLE) begin
							st_nxt.mode = FPK_RESET;
						end else if (core_in.kind != FPK_ITEM_MENU &&
								core_in.kind != FPK_ITEM_READONLY) begin
							st_nxt.mode = FPK_EDIT;
							st_nxt.ekind = core_in.kind;
							st_nxt.col = 5'h00;
						end
					end else if (|ap) begin
						// RQ18 shortcut in navigation
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_SHORTCUT;
						st_nxt.arg = key_code(ap);
					end
				end
				FPK_EDIT: begin
					if (kp.up || kp.down) begin
						st_nxt.cmd_valid = 1'b1;
						st_nxt.arg = 8'h00;
						if (st_r.ekind == FPK_ITEM_OPTION) begin
							// RQ9 option stepping
							st_nxt.cmd = kp.up ? FPK_CMD_OPT_PREV : FPK_CMD_OPT_NEXT;
						end else if (st_r.ekind == FPK_ITEM_NUMERIC) begin
							// RQ10 sign flip
							st_nxt.cmd = FPK_CMD_SIGN_FLIP;
						end else if (st_r.ekind == FPK_ITEM_PASSWORD) begin
							// RQ11 case toggle
							st_nxt.cmd = FPK_CMD_CASE_FLIP;
						end else begin
							st_nxt.cmd_valid = 1'b0;
						end
					end else if (kp.right) begin
						// RQ13 cursor right, RQ5 twenty columns
						if (st_r.col != 5'(`FPK_LCD_COLS - 1)) begin
							st_nxt.col = st_r.col + 5'h01;
						end
					end else if (kp.back_out_key) begin
						// RQ14 cancel without change
						st_nxt.mode = FPK_NAV;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_CANCEL;
					end else if (kp.enter) begin
						// RQ15 commit or confirm password
						st_nxt.mode = FPK_NAV;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = (st_r.ekind == FPK_ITEM_PASSWORD) ?
							FPK_CMD_CONFIRM_PWD : FPK_CMD_COMMIT;
					end else if (kp.special_char_key) begin
						// RQ19 special character
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_SPECIAL;
						st_nxt.arg = {3'h0, st_r.col};
					end else if (|ap) begin
						// RQ18 character entry
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_CHAR;
						st_nxt.arg = key_code(ap);
						if (st_r.col != 5'(`FPK_LCD_COLS - 1)) begin
							st_nxt.col = st_r.col + 5'h01;
						end
					end
				end
				FPK_RESET: begin
					if (kp.enter) begin
						// RQ15 confirm reset
						st_nxt.mode = FPK_NAV;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_CONFIRM_RESET;
					end else if (kp.back_out_key) begin
						st_nxt.mode = FPK_NAV;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_CANCEL;
					end
				end
				FPK_FUNCTION_KEY: begin
					if (kp.enter) begin
						// RQ15 execute function code
						st_nxt.mode = FPK_NAV;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_EXEC_FUNCTION_KEY;
					end else if (kp.back_out_key) begin
						st_nxt.mode = FPK_NAV;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_CANCEL;
					end else if (|ap) begin
						// RQ18 function code digits
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd = FPK_CMD_CHAR;
						st_nxt.arg = key_code(ap);
						if (st_r.col != 5'(`FPK_LCD_COLS - 1)) begin
							st_nxt.col = st_r.col + 5'h01;
						end
					end
				end
				default: begin
					st_nxt.mode = FPK_NAV;
				end
			endcase
		end

		// RQ4 idle return to root
		if (!any_press && st_r.root_tmr == IDLE_CYC - `FPK_TMR_W'(1)) begin
			st_nxt.mode = FPK_NAV;
			st_nxt.depth = 3'h0;
			st_nxt.item = 6'h00;
			st_nxt.row = 2'h0;
			st_nxt.col = 5'h00;
		end

		// RQ2 exempt leds follow demand
		// RQ3 others follow demand when awake
		st_nxt.led = st_nxt.saving ? (led_want & EXEMPT) : led_want;
		st_nxt.backlight = !st_nxt.saving;
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{mode: FPK_NAV, ekind: FPK_ITEM_MENU, cmd: FPK_CMD_NONE,
				contrast: `FPK_CONTRAST_RST, backlight: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign core_cmd = '{valid: st_r.cmd_valid, cmd: st_r.cmd, arg: st_r.arg};
	assign pos = '{mode: st_r.mode, depth: st_r.depth, item: st_r.item,
		row: st_r.row, col: st_r.col};
	assign backlight = st_r.backlight;
	assign contrast = st_r.contrast;
	assign led_out = st_r.led;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_idle_end;
		!any_press && st_r.save_tmr == IDLE_CYC - `FPK_TMR_W'(1);
	endsequence

	sequence s_nav_up;
		st_r.mode == FPK_NAV && kp.up && !kl.function_key && !st_r.fn_prev;
	endsequence

	AST_SAVE_BLANK: assert property (s_idle_end
		|=> !backlight && led_out == ($past(led_want) & EXEMPT)) // RQ1
		else $error("backlight or leds not off after idle time");
	AST_EXEMPT_LED: assert property (st_r.saving
		|=> (led_out & EXEMPT) == ($past(led_want) & EXEMPT)) // RQ2
		else $error("exempt led not driven while saving");
	AST_WAKE: assert property (any_press |=> backlight && led_out == $past(led_want)) // RQ3
		else $error("press did not wake panel");
	AST_ROOT: assert property (!any_press && st_r.root_tmr == IDLE_CYC - `FPK_TMR_W'(1)
		|=> pos.depth == 3'h0 && pos.item == 6'h00 && pos.mode == FPK_NAV) // RQ4
		else $error("menu not at root after idle time");
	AST_COL_RANGE: assert property (pos.col < 5'(`FPK_LCD_COLS)) // RQ5
		else $error("cursor column out of range");
	AST_CONTRAST_UP: assert property (kl.function_key && kp.up &&
		contrast != `FPK_CONTRAST_MAX |=> contrast == $past(contrast) + 4'h1) // RQ6
		else $error("contrast did not rise");
	AST_UP_WRAP: assert property (s_nav_up ##0 (pos.item == 6'h00 && core_in.item_count
		!= 6'h00) |=> pos.item == $past(core_in.item_count) - 6'h01) // RQ7
		else $error("up did not wrap to last item");
	AST_DOWN_WRAP: assert property (st_r.mode == FPK_NAV && kp.down && !kp.up && !kl.function_key &&
		!st_r.fn_prev && pos.item + 6'h01 >= core_in.item_count |=> pos.item == 6'h00) // RQ8
		else $error("down did not wrap to first item");
	AST_CANCEL: assert property (st_r.mode == FPK_EDIT && kp.back_out_key && !kl.function_key
		&& !st_r.fn_prev && !kp.up && !kp.down && !kp.right
		|=> pos.mode == FPK_NAV && core_cmd.cmd == FPK_CMD_CANCEL) // RQ14
		else $error("back-out did not cancel edit");
	AST_TMR_RESTART: assert property (any_press |=> st_r.save_tmr == '0 &&
		st_r.root_tmr == '0) // RQ20
		else $error("press did not restart idle timers");

endmodule
`default_nettype wire

// *** fpk_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------------
// operator side: keypad switches, display and leds
// --------------------------------------------------------------------
module fpk_panel_model
	import fpk_pkg::*;
#(
	parameter int DB_CYC = 3
) (
	// clock
	input wire logic clk,
	// keypad pins, high while pressed
	output fpk_pkg::fpk_keys_t keys_raw,
	output logic [9:0] alnum_raw,
	// display and leds seen by the operator
	input wire logic backlight,
	input wire logic [3:0] contrast,
	input wire logic [15:0] led_out
);
	fpk_keys_t held_r;

	// switches open at power-up
	initial begin
		keys_raw = '0;
		alnum_raw = '0;
		held_r = '0;
	end

	// keys kept down across other presses, settled past debounce
	task automatic hold(input fpk_keys_t k);
		@(posedge clk);
		held_r = k;
		keys_raw <= k;
		repeat (DB_CYC + 6) @(posedge clk);
	endtask

	// one bouncing press
	// contact chatters once, then held and released well past the debounce span
	task automatic press(input fpk_keys_t k, input logic [9:0] a);
		@(posedge clk);
		keys_raw <= held_r | k;
		alnum_raw <= a;
		@(posedge clk);
		keys_raw <= held_r;
		alnum_raw <= 10'h000;
		@(posedge clk);
		keys_raw <= held_r | k;
		alnum_raw <= a;
		repeat (DB_CYC + 6) @(posedge clk);
		keys_raw <= held_r;
		alnum_raw <= 10'h000;
		repeat (DB_CYC + 6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** fpk_hmi_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpk_hmi_bench;
	import fpk_pkg::*;
	// --------------------------------------------------------------------
	// signals and instances
	// --------------------------------------------------------------------
	localparam int DB = 3;
	localparam int IDLE = 200;
	localparam int K_UP = 8, K_DN = 7, K_LT = 6, K_RT = 5, K_BK = 4;
	localparam int K_EN = 3, K_ED = 2, K_FN = 1, K_SP = 0;
	logic clk;
	logic rst;
	fpk_keys_t keys_raw;
	logic [9:0] alnum_raw;
	fpk_core_in_t core_in;
	logic [15:0] led_want;
	fpk_core_cmd_t core_cmd;
	fpk_pos_t pos;
	logic backlight;
	logic [3:0] contrast;
	logic [15:0] led_out;
	int errors;
	int checks_done;
	logic [12:0] exp_q[$];
	logic [12:0] e;
	logic [31:0] rnd_r;
	logic [3:0] code;
	logic [5:0] n;
	fpk_cmd_t cu, cd;

	fpk_hmi #(.IDLE_CYC(36'h0C8), .DB_CYC(DB)) uut (.clk(clk), .rst(rst),
		.keys_raw(keys_raw), .alnum_raw(alnum_raw), .core_in(core_in),
		.led_want(led_want), .core_cmd(core_cmd), .pos(pos),
		.backlight(backlight), .contrast(contrast), .led_out(led_out));
	fpk_panel_model #(.DB_CYC(DB)) panel (.clk(clk), .keys_raw(keys_raw),
		.alnum_raw(alnum_raw), .backlight(backlight), .contrast(contrast),
		.led_out(led_out));

	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	task automatic next_code;
		rnd_r = xs(rnd_r);
		code = 4'(rnd_r % 10);
	endtask
	task automatic key(input int i);
		panel.press(fpk_keys_t'(9'h001 << i), 10'h000);
	endtask
	task automatic alnum(input logic [3:0] c);
		panel.press('0, 10'h001 << c);
	endtask
	// arg compared only where the command carries one
	task automatic note_cmd(input fpk_cmd_t c, input logic care, input logic [7:0] a);
		exp_q.push_back({care, c, a & {8{care}}});
	endtask
	task automatic chk_pos(input fpk_mode_t m, input logic [2:0] d, input logic [5:0] it);
		check("mode", pos.mode, m);
		check("depth", pos.depth, d);
		check("item", pos.item, it);
	endtask
	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	// clock source
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// command watcher: oldest note against each command pulse
	always @(posedge clk) begin
		if (rst === 1'b0 && core_cmd.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected command", 32'(core_cmd.cmd), 32'h0000_0000);
			end else begin
				e = exp_q.pop_front();
				check("command", {core_cmd.cmd, core_cmd.arg & {8{e[12]}}}, e[11:0]);
			end
		end
	end

	// watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("Error watchdog expected finish seen timeout");
		stop_test();
	end

	// --------------------------------------------------------------------
	// tests
	// --------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		rnd_r = 32'h0000_005B;
		core_in = '{item_count: 6'h05, has_child: 1'b1, kind: FPK_ITEM_MENU};
		led_want = 16'hA5C3;
		errors = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		check("contrast reset", contrast, 4'h8);
		check("backlight reset", backlight, 1'b1);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check("leds after reset", led_out, led_want);
		end_test("reset");
		// wrap on a random level length
		next_code();
		n = 6'(2 + rnd_r % 30);
		core_in.item_count <= n;
		key(K_UP);
		chk_pos(FPK_NAV, 3'h0, n - 6'h01);
		check("row", pos.row, (n > 6'h04) ? 2'h3 : 2'(n - 6'h01));
		key(K_DN);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		key(K_DN);
		chk_pos(FPK_NAV, 3'h0, 6'h01);
		check("row", pos.row, 2'h1);
		key(K_UP);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		end_test("wrap");
		// levels down and back up
		key(K_RT);
		chk_pos(FPK_NAV, 3'h1, 6'h00);
		key(K_EN);
		chk_pos(FPK_NAV, 3'h2, 6'h00);
		key(K_LT);
		chk_pos(FPK_NAV, 3'h1, 6'h00);
		key(K_BK);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		key(K_LT);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		core_in.has_child <= 1'b0;
		key(K_EN);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		core_in.has_child <= 1'b1;
		next_code();
		note_cmd(FPK_CMD_SHORTCUT, 1'b1, 8'(code));
		alnum(code);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		end_test("levels");
		// option, numeric and password edits
		for (int i = 1; i <= 3; i++) begin
			@(posedge clk);
			core_in.kind <= fpk_item_t'(i);
			cu = (i == 1) ? FPK_CMD_OPT_PREV : (i == 2) ? FPK_CMD_SIGN_FLIP : FPK_CMD_CASE_FLIP;
			cd = (i == 1) ? FPK_CMD_OPT_NEXT : cu;
			key(K_ED);
			chk_pos(FPK_EDIT, 3'h0, 6'h00);
			note_cmd(cu, 1'b0, 8'h00);
			key(K_UP);
			note_cmd(cd, 1'b0, 8'h00);
			key(K_DN);
			note_cmd((i == 3) ? FPK_CMD_CONFIRM_PWD : FPK_CMD_COMMIT, 1'b0, 8'h00);
			key(K_EN);
			chk_pos(FPK_NAV, 3'h0, 6'h00);
		end
		end_test("edit kinds");
		// scalar text entry with cursor saturation
		@(posedge clk);
		core_in.kind <= FPK_ITEM_SCALAR;
		key(K_ED);
		key(K_RT);
		check("cursor right", pos.col, 5'h01);
		key(K_UP);
		for (int i = 0; i < 20; i++) begin
			next_code();
			note_cmd(FPK_CMD_CHAR, 1'b1, 8'(code));
			alnum(code);
		end
		check("cursor limit", pos.col, 5'h13);
		note_cmd(FPK_CMD_SPECIAL, 1'b1, 8'h13);
		key(K_SP);
		note_cmd(FPK_CMD_CANCEL, 1'b0, 8'h00);
		key(K_BK);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		end_test("scalar");
		// resettable item: abandon, then confirm
		@(posedge clk);
		core_in.kind <= FPK_ITEM_RESETTABLE;
		key(K_ED);
		chk_pos(FPK_RESET, 3'h0, 6'h00);
		note_cmd(FPK_CMD_CANCEL, 1'b0, 8'h00);
		key(K_BK);
		key(K_ED);
		note_cmd(FPK_CMD_CONFIRM_RESET, 1'b0, 8'h00);
		key(K_EN);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		end_test("reset item");
		// function code entry
		@(posedge clk);
		core_in.kind <= FPK_ITEM_READONLY;
		key(K_ED);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		key(K_FN);
		chk_pos(FPK_FUNCTION_KEY, 3'h0, 6'h00);
		note_cmd(FPK_CMD_CANCEL, 1'b0, 8'h00);
		key(K_BK);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		core_in.kind <= FPK_ITEM_MENU;
		key(K_ED);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		key(K_FN);
		chk_pos(FPK_FUNCTION_KEY, 3'h0, 6'h00);
		next_code();
		note_cmd(FPK_CMD_CHAR, 1'b1, 8'(code));
		alnum(code);
		note_cmd(FPK_CMD_EXEC_FUNCTION_KEY, 1'b0, 8'h00);
		key(K_EN);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		end_test("function code");
		// contrast steps and upper clamp
		panel.hold(fpk_keys_t'(9'h001 << K_FN));
		key(K_UP);
		check("contrast up", contrast, 4'h9);
		key(K_DN);
		key(K_DN);
		check("contrast down", contrast, 4'h7);
		repeat (9) key(K_UP);
		check("contrast clamp", contrast, 4'hF);
		panel.hold('0);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		end_test("contrast");
		// idle blanking, root return, wake
		key(K_RT);
		repeat (IDLE - 30) @(posedge clk);
		key(K_DN);
		repeat (IDLE - 30) @(posedge clk);
		check("backlight kept", backlight, 1'b1);
		repeat (40) @(posedge clk);
		check("backlight idle", backlight, 1'b0);
		check("leds idle", led_out, led_want & 16'h0003);
		chk_pos(FPK_NAV, 3'h0, 6'h00);
		next_code();
		led_want <= rnd_r[15:0];
		repeat (3) @(posedge clk);
		check("exempt leds", led_out, led_want & 16'h0003);
		key(K_LT);
		check("backlight wake", backlight, 1'b1);
		check("leds wake", led_out, led_want);
		end_test("idle");
		check("pending commands", exp_q.size(), 32'h0000_0000);
		stop_test();
	end
endmodule
`default_nettype wire
